// ===== rtl/ppps_top.sv
// Purpose: Data port, control port and slave parallel port with status flags.
// Assumes: One 200 MHz clock; pins arrive asynchronously and are synchronised.
// Notes:   Pins use separate input, output and output enable signals.
//
// The strobed register port was decided locally.
`default_nettype none

// Functional notes
// - Control pins each input or output.
// - Mode bit turns control pins into strobes.
// - Analog control pin reads as zero.
// - Direction bits still drive analog pins.
// - Power-on leaves control pins analog.
// - Status register resets to 0000 -111.
// - Bit 7 shows unread received word.
// - Bit 6 shows unread output word.
// - Bit 5 sticky overflow, software clears.
// - Bit 4 selects slave port mode.
// - Bits 2..0 direct select, write, read.
// - Low read strobe presents data latch.
// - Low write strobe loads input latch.
// - Strobes count only while select low.
// - Data pins are I/O or bus bits.
// - Data direction resets all inputs.
// - Control latch has three bits only.
// - Outside mode, full flags held clear.
// - Input-full cleared by latch read or leaving mode.
// - Output-full clears when external read starts.
// - Separate latches; direction ignored in mode.
module ppps_top
(
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	input  wire logic [7:0] data_pin_in,
	output var  logic [7:0] data_pin_out,
	output var  logic [7:0] data_pin_oe,
	input  wire logic [2:0] ctrl_pin_in,
	output var  logic [2:0] ctrl_pin_out,
	output var  logic [2:0] ctrl_pin_oe
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] data_port_latch_r;
	logic [7:0] input_latch_r;
	logic [7:0] data_port_direction_r;
	logic [2:0] control_port_latch_r;
	logic [2:0] control_dir_r;
	logic       slave_port_mode_select_r;
	logic       input_full_flag_r;
	logic       output_full_flag_r;
	logic       input_overflow_flag_r;
	logic [7:0] analog_pin_configuration_r;
	logic [7:0] data_sync1_r;
	logic [7:0] data_sync2_r;
	logic [2:0] ctrl_sync1_r;
	logic [2:0] ctrl_sync2_r;
	logic       wr_active_r;
	logic       rd_active_r;
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Two-stage synchronisers.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data_sync1_r <= 8'h00;
			data_sync2_r <= 8'h00;
			ctrl_sync1_r <= 3'h7;
			ctrl_sync2_r <= 3'h7;
		end
		else
		begin
			data_sync1_r <= data_pin_in;
			data_sync2_r <= data_sync1_r;
			ctrl_sync1_r <= ctrl_pin_in;
			ctrl_sync2_r <= ctrl_sync1_r;
		end
	end

	// ----------------------------------------------------------------
	// Strobe decode
	// ----------------------------------------------------------------
	logic analog_sel;
	logic sel_low;
	logic wr_low;
	logic rd_low;
	logic wr_start;
	logic wr_end;
	logic rd_start;
	logic cpu_rd_data;
	logic cpu_wr_data;
	// Analog field below the digital setting keeps pins analog.
	assign analog_sel = analog_pin_configuration_r[3:0] < ppps_pkg::ANALOG_FIELD_DIGITAL_MIN;
	assign sel_low  = slave_port_mode_select_r & ~ctrl_sync2_r[ppps_pkg::CTRL_PIN_SELECT];
	assign wr_low   = sel_low & ~ctrl_sync2_r[ppps_pkg::CTRL_PIN_WRITE];
	assign rd_low   = sel_low & ~ctrl_sync2_r[ppps_pkg::CTRL_PIN_READ];
	assign wr_start = wr_low & ~wr_active_r;
	assign wr_end   = wr_active_r & ~wr_low;
	assign rd_start = rd_low & ~rd_active_r;
	assign cpu_rd_data = reg_rd && reg_addr == ppps_pkg::ADDR_DATA_PORT_LATCH;
	assign cpu_wr_data = reg_wr && reg_addr == ppps_pkg::ADDR_DATA_PORT_LATCH;
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_active_r <= 1'b0;
			rd_active_r <= 1'b0;
		end
		else
		begin
			wr_active_r <= wr_low;
			rd_active_r <= rd_low;
		end
	end

	// ----------------------------------------------------------------
	// Data port latches
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data_port_latch_r <= ppps_pkg::RST_DATA_PORT_LATCH;
		end
		else if (cpu_wr_data)
		begin
			data_port_latch_r <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			input_latch_r <= 8'h00;
		end
		else if (wr_low)
		begin
			input_latch_r <= data_sync2_r;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data_port_direction_r <= ppps_pkg::RST_DATA_PORT_DIR;
		end
		else if (reg_wr && reg_addr == ppps_pkg::ADDR_DATA_PORT_DIR)
		begin
			data_port_direction_r <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Control port and configuration
	// ----------------------------------------------------------------
	// Three implemented bits.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			control_port_latch_r <= ppps_pkg::RST_CONTROL_LATCH;
		end
		else if (reg_wr && reg_addr == ppps_pkg::ADDR_CONTROL_PORT_LATCH)
		begin
			control_port_latch_r <= reg_wdata[2:0];
		end
	end

	// Writable fields reset to -111 and mode off.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			control_dir_r            <= ppps_pkg::RST_CONTROL_DIR;
			slave_port_mode_select_r <= 1'b0;
		end
		else if (reg_wr && reg_addr == ppps_pkg::ADDR_CTRL_DIR_STATUS)
		begin
			control_dir_r            <= reg_wdata[2:0];
			slave_port_mode_select_r <= reg_wdata[ppps_pkg::BIT_MODE_SELECT];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			analog_pin_configuration_r <= ppps_pkg::RST_ANALOG_PIN_CFG;
		end
		else if (reg_wr && reg_addr == ppps_pkg::ADDR_ANALOG_PIN_CFG)
		begin
			analog_pin_configuration_r <= reg_wdata & ppps_pkg::ANALOG_CFG_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Input-full set at write end.
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			input_full_flag_r <= 1'b0;
		end
		else if (!slave_port_mode_select_r)
		begin
			input_full_flag_r <= 1'b0;
		end
		else if (wr_end)
		begin
			input_full_flag_r <= 1'b1;
		end
		else if (cpu_rd_data)
		begin
			input_full_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			input_overflow_flag_r <= 1'b0;
		end
		else if (wr_start && input_full_flag_r)
		begin
			input_overflow_flag_r <= 1'b1;
		end
		else if (reg_wr && reg_addr == ppps_pkg::ADDR_CTRL_DIR_STATUS)
		begin
			input_overflow_flag_r <= reg_wdata[ppps_pkg::BIT_OVERFLOW];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			output_full_flag_r <= 1'b0;
		end
		else if (!slave_port_mode_select_r)
		begin
			output_full_flag_r <= 1'b0;
		end
		else if (rd_start)
		begin
			output_full_flag_r <= 1'b0;
		end
		else if (cpu_wr_data)
		begin
			output_full_flag_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_data_pin
			always_ff @(posedge clk_sys or negedge arst_n)
			begin
				if (!arst_n)
				begin
					data_pin_out[gi] <= 1'b0;
					data_pin_oe[gi]  <= 1'b0;
				end
				else
				begin
					data_pin_out[gi] <= data_port_latch_r[gi];
					data_pin_oe[gi]  <= slave_port_mode_select_r ? rd_low
						: ~data_port_direction_r[gi];
				end
			end
		end
	endgenerate
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_ctrl_pin
			always_ff @(posedge clk_sys or negedge arst_n)
			begin
				if (!arst_n)
				begin
					ctrl_pin_out[gi] <= 1'b0;
					ctrl_pin_oe[gi]  <= 1'b0;
				end
				else
				begin
					ctrl_pin_out[gi] <= control_port_latch_r[gi] & ~slave_port_mode_select_r;
					ctrl_pin_oe[gi]  <= ~control_dir_r[gi] & ~slave_port_mode_select_r;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	logic [7:0] rdata_nxt;
	always_comb
	begin
		case (reg_addr)
			ppps_pkg::ADDR_DATA_PORT_LATCH:
			begin
				rdata_nxt = slave_port_mode_select_r ? input_latch_r : data_sync2_r;
			end
			ppps_pkg::ADDR_CONTROL_PORT_LATCH:
			begin
				rdata_nxt = analog_sel ? 8'h00 : {5'h00, ctrl_sync2_r};
			end
			ppps_pkg::ADDR_DATA_PORT_DIR:    rdata_nxt = data_port_direction_r;
			ppps_pkg::ADDR_CTRL_DIR_STATUS:
			begin
				rdata_nxt = {input_full_flag_r, output_full_flag_r, input_overflow_flag_r,
					slave_port_mode_select_r, 1'b0, control_dir_r};
			end
			ppps_pkg::ADDR_ANALOG_PIN_CFG:   rdata_nxt = analog_pin_configuration_r;
			default:                         rdata_nxt = 8'h00;
		endcase
	end
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata <= 8'h00;
		end
		else
		begin
			reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
		end
	end

endmodule
`default_nettype wire

// ===== include/ppps_pkg.sv
// Purpose: Constants for the parallel port pins and status block.
// Assumes: Register port with byte-wide data and 8-bit register addresses.
// Notes:   Offsets are the printed register addresses.
`default_nettype none
package ppps_pkg;
	localparam logic [7:0] ADDR_DATA_PORT_LATCH    = 8'h08;
	localparam logic [7:0] ADDR_CONTROL_PORT_LATCH = 8'h09;
	localparam logic [7:0] ADDR_DATA_PORT_DIR      = 8'h88;
	localparam logic [7:0] ADDR_CTRL_DIR_STATUS    = 8'h89;
	localparam logic [7:0] ADDR_ANALOG_PIN_CFG     = 8'h9f;

	localparam logic [7:0] RST_DATA_PORT_DIR       = 8'hff;
	localparam logic [7:0] RST_DATA_PORT_LATCH     = 8'h00;
	localparam logic [2:0] RST_CONTROL_LATCH       = 3'h0;
	localparam logic [2:0] RST_CONTROL_DIR         = 3'h7;
	localparam logic [7:0] RST_ANALOG_PIN_CFG      = 8'h00;
	localparam logic [7:0] ANALOG_CFG_WMASK        = 8'h8f;

	localparam int BIT_INPUT_FULL     = 7;
	localparam int BIT_OUTPUT_FULL    = 6;
	localparam int BIT_OVERFLOW       = 5;
	localparam int BIT_MODE_SELECT    = 4;
	localparam int CTRL_PIN_READ      = 0;
	localparam int CTRL_PIN_WRITE     = 1;
	localparam int CTRL_PIN_SELECT    = 2;
	localparam int SYNC_STAGES        = 2;

	// Analog field value from which all three control pins read digital.
	localparam logic [3:0] ANALOG_FIELD_DIGITAL_MIN = 4'h2;
endpackage
`default_nettype wire

// ===== bench/ppps_monitor.sv
// Purpose: Port assertions for the parallel port block.
// Assumes: Register writes are mirrored in helper logic.
// Notes:   Bound to ppps_top below.
`default_nettype none
module ppps_monitor
(
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] data_pin_out,
	input wire logic [7:0] data_pin_oe,
	input wire logic [2:0] ctrl_pin_in,
	input wire logic [2:0] ctrl_pin_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] A_ST = ppps_pkg::ADDR_CTRL_DIR_STATUS;
	localparam logic [7:0] A_CL = ppps_pkg::ADDR_CONTROL_PORT_LATCH;
	logic       mode_r;
	logic [1:0] mode_q;
	logic [7:0] ddir_r;
	logic [7:0] dlat_r;
	logic [2:0] cdir_r;
	logic [3:0] acfg_r;
	logic [1:0] quiet_r;
	logic       rd_v_q;
	logic [7:0] rd_a_q;
	// ----------------
	// Register mirrors
	// ----------------
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{mode_r, mode_q, quiet_r, rd_v_q, rd_a_q, acfg_r} <= '0;
			ddir_r <= ppps_pkg::RST_DATA_PORT_DIR;
			dlat_r <= ppps_pkg::RST_DATA_PORT_LATCH;
			cdir_r <= ppps_pkg::RST_CONTROL_DIR;
		end
		else
		begin
			rd_v_q <= reg_rd;
			rd_a_q <= reg_addr;
			mode_q <= {mode_q[0], mode_r};
			quiet_r <= reg_wr ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
			if (reg_wr)
				case (reg_addr)
					A_ST: {mode_r, cdir_r} <= {reg_wdata[4], reg_wdata[2:0]};
					ppps_pkg::ADDR_DATA_PORT_DIR: ddir_r <= reg_wdata;
					ppps_pkg::ADDR_DATA_PORT_LATCH: dlat_r <= reg_wdata;
					ppps_pkg::ADDR_ANALOG_PIN_CFG: acfg_r <= reg_wdata[3:0];
					default: ;
				endcase
		end
	end
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	sequence seq_read_held;
		(mode_r && ctrl_pin_in == 3'b010) [*6];
	endsequence
	sequence seq_read_start;
		(mode_r && ctrl_pin_in == 3'b111 && data_pin_oe == 8'h00) ##1
		(mode_r && ctrl_pin_in == 3'b010);
	endsequence
	AST_STAT_B3: assert property (rd_v_q && rd_a_q == A_ST |-> !reg_rdata[3])
		else $error("status bit 3 set");
	AST_CTRL_HI: assert property (rd_v_q && rd_a_q == A_CL |-> reg_rdata[7:3] == 5'h00)
		else $error("control upper bits set");
	AST_ANALOG_ZERO: assert property (rd_v_q && rd_a_q == A_CL &&
		acfg_r < ppps_pkg::ANALOG_FIELD_DIGITAL_MIN |-> reg_rdata == 8'h00)
		else $error("analog pin read not zero");
	AST_FLAGS_CLEAR: assert property (rd_v_q && rd_a_q == A_ST && mode_q == 2'h0
		|-> reg_rdata[7:6] == 2'h0)
		else $error("full flags set outside mode");
	AST_DATA_IO: assert property (quiet_r == 2'h3 && !mode_r |-> data_pin_oe == ~ddir_r &&
		((data_pin_out ^ dlat_r) & ~ddir_r) == 8'h00)
		else $error("data pins differ from direction");
	AST_CTRL_DIR: assert property (quiet_r == 2'h3 && !mode_r |-> ctrl_pin_oe == ~cdir_r)
		else $error("control enable differs from direction");
	AST_READ_DRIVE: assert property (seq_read_held |-> data_pin_oe == 8'hff &&
		data_pin_out == dlat_r)
		else $error("external read not served");
	AST_UNSEL: assert property ((mode_r && ctrl_pin_in[2]) [*6] |-> data_pin_oe == 8'h00)
		else $error("data driven while unselected");
	AST_SYNC: assert property (seq_read_start |-> data_pin_oe == 8'h00 ##1 data_pin_oe == 8'h00)
		else $error("read answered before synchronising");
endmodule
bind ppps_top ppps_monitor ppps_monitor_i
(
	.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_pin_out(data_pin_out),
	.data_pin_oe(data_pin_oe), .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_oe(ctrl_pin_oe)
);
`default_nettype wire

// ===== bench/ppps_host_model.sv
// Purpose: External processor that strobes the slave port.
// Assumes: Strobes idle high; each level lasts several cycles.
// Notes:   A released bus shows the inverse of the last byte.
`default_nettype none
module ppps_host_model
(
	input  wire logic       clk_sys,
	input  wire logic [7:0] bus_level,
	output wire logic [7:0] bus_val,
	output var  logic [2:0] strobe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       drive_r = 1'b0;
	logic [7:0] drv_r = 8'h00;
	logic [7:0] last_r = 8'h00;
	initial strobe_n = 3'b111;
	assign bus_val = drive_r ? drv_r : ~last_r;
	task automatic xfer(input logic rd, input logic sel, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys);
		strobe_n <= {~sel, rd, ~rd};
		drive_r <= ~rd;
		drv_r <= d;
		repeat (6) @(posedge clk_sys);
		q = bus_level;
		strobe_n <= 3'b111;
		repeat (2) @(posedge clk_sys);
		drive_r <= 1'b0;
		last_r <= d;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ===== bench/ppps_top_bench.sv
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Register port reads answer one cycle later.
// Notes:   Pin wires are resolved from all enables.
`default_nettype none
module ppps_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] A_DL = ppps_pkg::ADDR_DATA_PORT_LATCH;
	localparam logic [7:0] A_CL = ppps_pkg::ADDR_CONTROL_PORT_LATCH;
	localparam logic [7:0] A_DD = ppps_pkg::ADDR_DATA_PORT_DIR;
	localparam logic [7:0] A_ST = ppps_pkg::ADDR_CTRL_DIR_STATUS;
	localparam logic [7:0] A_AC = ppps_pkg::ADDR_ANALOG_PIN_CFG;
	logic       clk_sys;
	logic       arst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic [7:0] data_pin_out;
	logic [7:0] data_pin_oe;
	logic [2:0] ctrl_pin_out;
	logic [2:0] ctrl_pin_oe;
	logic [7:0] bus_val;
	logic [2:0] strobe_n;
	logic [7:0] q;
	int         n_fail = 0;
	int         compares = 0;
	wire logic [7:0] data_pin_in = (data_pin_oe & data_pin_out) | (~data_pin_oe & bus_val);
	wire logic [2:0] ctrl_pin_in = (ctrl_pin_oe & ctrl_pin_out) | (~ctrl_pin_oe & strobe_n);
	ppps_top ppps_top_i
	(
		.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_pin_in(data_pin_in),
		.data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .ctrl_pin_in(ctrl_pin_in),
		.ctrl_pin_out(ctrl_pin_out), .ctrl_pin_oe(ctrl_pin_oe)
	);
	ppps_host_model ppps_host_model_i
	(
		.clk_sys(clk_sys), .bus_level(data_pin_in), .bus_val(bus_val), .strobe_n(strobe_n)
	);
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		check(name, exp, reg_rdata);
	endtask
	task t_reset;
		rd(A_ST, 8'h07, "status reset");
		rd(A_DD, 8'hff, "data dir reset");
		rd(A_CL, 8'h00, "control analog");
		rd(8'h10, 8'h00, "unmapped");
		wr(A_ST, 8'hff);
		rd(A_ST, 8'h37, "status access");
		wr(A_ST, 8'h07);
		rd(A_ST, 8'h07, "mode off");
	endtask
	task t_gpio;
		wr(A_AC, 8'h06);
		wr(A_CL, 8'h05);
		wr(A_ST, 8'h02);
		wr(A_DD, 8'hf0);
		wr(A_DL, 8'ha5);
		rd(A_CL, 8'h07, "control pins");
		check("control oe", 8'h05, {5'h00, ctrl_pin_oe});
		check("data oe", 8'h0f, data_pin_oe);
		check("data out", 8'h05, data_pin_out & 8'h0f);
		rd(A_DL, 8'hf5, "data pins");
		wr(A_AC, 8'h00);
		rd(A_CL, 8'h00, "analog zero");
		check("analog oe", 8'h05, {5'h00, ctrl_pin_oe});
		wr(A_ST, 8'h07);
		wr(A_DD, 8'hff);
	endtask
	task t_slave_in;
		wr(A_AC, 8'h06);
		wr(A_ST, 8'h17);
		ppps_host_model_i.xfer(1'b0, 1'b1, 8'h3c, q);
		rd(A_ST, 8'h97, "input full");
		wr(A_ST, 8'h17);
		rd(A_ST, 8'h97, "full kept");
		ppps_host_model_i.xfer(1'b0, 1'b1, 8'h5c, q);
		rd(A_ST, 8'hb7, "overflow");
		rd(A_DL, 8'h5c, "input latch");
		rd(A_ST, 8'h37, "sticky overflow");
		wr(A_ST, 8'h17);
		rd(A_ST, 8'h17, "overflow cleared");
	endtask
	task t_slave_out;
		wr(A_DL, 8'h5a);
		rd(A_ST, 8'h57, "output full");
		ppps_host_model_i.xfer(1'b0, 1'b0, 8'h11, q);
		ppps_host_model_i.xfer(1'b1, 1'b0, 8'h00, q);
		rd(A_ST, 8'h57, "unselected");
		ppps_host_model_i.xfer(1'b1, 1'b1, 8'h00, q);
		check("external read", 8'h5a, q);
		rd(A_ST, 8'h17, "output read");
		ppps_host_model_i.xfer(1'b0, 1'b1, 8'h77, q);
		wr(A_DL, 8'h66);
		rd(A_ST, 8'hd7, "both full");
		wr(A_ST, 8'h07);
		rd(A_ST, 8'h07, "flags clear");
	endtask
	task automatic finish_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		finish_test;
	end
	initial
	begin
		{arst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset;
		t_gpio;
		t_slave_in;
		t_slave_out;
		finish_test;
	end
endmodule
`default_nettype wire
